// [sim/stw_mem_model.sv]
// external memory model: stretches each access with its wait line
// assumes acc_busy marks an access in progress on the same clock
`timescale 1ns/1ps
`default_nettype none

module stw_mem_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // access in progress and stall length
  input  wire logic       acc_busy,
  input  wire logic [3:0] stall,
  // wait line, active low
  output logic            wait_n
);
  logic [3:0] left_ff;
  logic       busy_ff;

  // stall starts one clock after acc_busy rises; zero-wait first cycles ignore it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 4'h0;
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= acc_busy;
      if (acc_busy && !busy_ff) begin
        left_ff <= stall;
      end else if (left_ff != 4'h0) begin
        left_ff <= left_ff - 4'h1;
      end
    end
  end

  // stall code f holds the line low for as long as it stands
  assign wait_n = (left_ff == 4'h0) && (stall != 4'hf);
endmodule : stw_mem_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the wait-state and sdram timing controller
// assumes stw_ctrl on a 25 MHz pclk and the memory model on wait_n
`timescale 1ns/1ps
`default_nettype none
`include "stw_map.svh"

module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        wait_n, manual_reset_n, standby_req, acc_req, acc_write, refresh_req;
  logic        acc_busy, beat_done, acc_done, sd_activate, sd_read, sd_write;
  logic        sd_precharge, sd_auto_refresh, sd_self_refresh;
  logic [1:0]  acc_area, cas_latency;
  logic [3:0]  acc_beats, stall, row_start_bit;
  int          num_errors, total_checks, cyc, t0, t_beat, t_prev, t_act, t_rd, t_ar;
  int          i, old, t1, t_pre, t_wr;
  int          a0w[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
  int          a0p[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
  int          clt[4] = '{1, 1, 2, 3};

  stw_ctrl i_stw_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_n(wait_n), .manual_reset_n(manual_reset_n),
    .standby_req(standby_req), .acc_req(acc_req), .acc_area(acc_area),
    .acc_write(acc_write), .acc_beats(acc_beats), .refresh_req(refresh_req),
    .acc_busy(acc_busy), .beat_done(beat_done), .acc_done(acc_done),
    .sd_activate(sd_activate), .sd_read(sd_read), .sd_write(sd_write),
    .sd_precharge(sd_precharge), .sd_auto_refresh(sd_auto_refresh),
    .sd_self_refresh(sd_self_refresh), .cas_latency(cas_latency),
    .row_start_bit(row_start_bit));

  stw_mem_model i_stw_mem_model (.pclk(pclk), .presetn(presetn), .acc_busy(acc_busy),
    .stall(stall), .wait_n(wait_n));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // cycle count moves on the falling edge so rising-edge readers see it settled
  always @(negedge pclk) cyc <= cyc + 1;

  always @(posedge pclk) begin
    if (beat_done === 1'b1) begin
      t_prev <= t_beat;
      t_beat <= cyc;
    end
    if (sd_activate === 1'b1) t_act <= cyc;
    if (sd_read === 1'b1) t_rd <= cyc;
    if (sd_auto_refresh === 1'b1) t_ar <= cyc;
    if (sd_precharge === 1'b1) t_pre <= cyc;
    if (sd_write === 1'b1) t_wr <= cyc;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic hang;
    num_errors++;
    close_out();
  endtask : hang

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // request held until taken; a lockout may delay the take
  task automatic acc(input logic [1:0] ar, input logic w, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge pclk);
    acc_req   <= 1'b1;
    acc_area  <= ar;
    acc_write <= w;
    acc_beats <= b;
    t0 = cyc;
    do begin
      @(posedge pclk);
      n++;
    end while (acc_busy !== 1'b1 && n < 50);
    acc_req <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (acc_done !== 1'b1 && n < 200);
    if (n >= 200) hang();
    repeat (2) @(posedge pclk);
  endtask : acc

  task automatic pulse_refresh;
    @(posedge pclk);
    refresh_req <= 1'b1;
    @(posedge pclk);
    refresh_req <= 1'b0;
    // room for a precharge of an open row ahead of the refresh
    repeat (6) @(posedge pclk);
  endtask : pulse_refresh

  task automatic sc_regs;
    apb(1'b0, `STW_OFF_WCR, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b0, `STW_OFF_MTC, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b1, `STW_OFF_MTC, 32'hffffffff);
    apb(1'b0, `STW_OFF_MTC, 32'h0);
    chk(rd, 32'h0000fffe);
    chk(row_start_bit, `STW_ROW_NONE);
    apb(1'b1, `STW_OFF_MTC, 32'h0020);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    chk(row_start_bit, `STW_ROW_A9);
  endtask : sc_regs

  task automatic sc_area0;
    for (i = 0; i < 8; i++) begin
      apb(1'b1, `STW_OFF_WCR, 32'hfff8 | i);
      acc(`STW_AREA0, 1'b0, 4'h1);
      chk(t_prev - t0, a0w[i] + 3);
      chk(t_beat - t_prev, a0p[i]);
    end
  endtask : sc_area0

  task automatic sc_area2;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `STW_OFF_WCR, 32'hffe7 | (i << 3));
      acc(`STW_AREA2, 1'b0, 4'h0);
      chk(t_beat - t0, i + 3);
    end
  endtask : sc_area2

  task automatic sc_wait_pin;
    // wait line held low already: zero-wait code must ignore it
    stall <= 4'hf;
    apb(1'b1, `STW_OFF_WCR, 32'hffe7);
    acc(`STW_AREA2, 1'b0, 4'h0);
    chk(t_beat - t0, 3);
    stall <= 4'h8;
    apb(1'b1, `STW_OFF_WCR, 32'hfff8);
    acc(`STW_AREA3, 1'b0, 4'h0);
    chk(t_beat - t0 > 6, 1);
    // third beat lands inside the stall: burst beats honour the pin
    acc(`STW_AREA0, 1'b0, 4'h2);
    chk(t_beat - t_prev > 2, 1);
    stall <= 4'h0;
  endtask : sc_wait_pin

  task automatic sc_sdram;
    apb(1'b1, `STW_OFF_ATY, 32'h1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `STW_OFF_MTC, (i << 12) | 32'h0020);
      apb(1'b1, `STW_OFF_WCR, 32'hffe7 | (i << 3));
      acc(`STW_AREA2, 1'b0, 4'h0);
      chk(t_rd - t_act, i + 1);
      chk(t_beat - t_rd, clt[i]);
      chk(cas_latency, clt[i]);
    end
  endtask : sc_sdram

  task automatic sc_lockout;
    apb(1'b1, `STW_OFF_MTC, 32'hc820);
    acc(`STW_AREA2, 1'b1, 4'h0);
    chk(t_wr - t_act, 1);
    t1 = t_beat;
    acc(`STW_AREA2, 1'b0, 4'h0);
    chk(t_act - t1 >= 7, 1);
    t1 = t_beat;
    acc(`STW_AREA2, 1'b0, 4'h0);
    chk(t_act - t1 >= 4, 1);
    // bank active: row stays open, next access precharges first
    apb(1'b1, `STW_OFF_MTC, 32'hc8a0);
    acc(`STW_AREA2, 1'b0, 4'h0);
    acc(`STW_AREA2, 1'b0, 4'h0);
    chk(t_act - t_pre > 4, 1);
  endtask : sc_lockout

  task automatic sc_refresh;
    apb(1'b1, `STW_OFF_MTC, 32'h0324);
    old = t_ar;
    pulse_refresh();
    chk(t_ar != old, 1);
    acc(`STW_AREA2, 1'b0, 4'h0);
    chk(t_act - t_ar > 6, 1);
    apb(1'b1, `STW_OFF_MTC, 32'h0326);
    repeat (4) @(posedge pclk);
    chk(sd_self_refresh, 1'b1);
    old = t_ar;
    pulse_refresh();
    chk(t_ar == old, 1);
    apb(1'b1, `STW_OFF_MTC, 32'h0320);
    repeat (4) @(posedge pclk);
    chk(sd_self_refresh, 1'b0);
  endtask : sc_refresh

  task automatic sc_retention;
    apb(1'b1, `STW_OFF_MTC, 32'h1230);
    apb(1'b1, `STW_OFF_WCR, 32'h0055);
    manual_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    manual_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `STW_OFF_MTC, 32'h0);
    chk(rd, 32'h00001230);
    apb(1'b0, `STW_OFF_WCR, 32'h0);
    chk(rd, 32'h00000055);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `STW_OFF_MTC, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, `STW_OFF_WCR, 32'h0);
    chk(rd, 32'h0000ffff);
  endtask : sc_retention

  initial begin
    cyc = 0;
    num_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    manual_reset_n = 1'b1;
    standby_req = 1'b0;
    acc_req = 1'b0;
    acc_area = 2'h0;
    acc_write = 1'b0;
    acc_beats = 4'h0;
    refresh_req = 1'b0;
    stall = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    sc_regs();
    sc_area0();
    sc_area2();
    sc_wait_pin();
    sc_sdram();
    sc_lockout();
    sc_refresh();
    sc_retention();
    close_out();
  end
endmodule : testbench
`default_nettype wire

// [src/stw_ctrl.sv]
// wait-state, burst pitch and sdram timing controller with apb registers
// assumes apb master on pclk; wait_n, manual_reset_n and standby_req are async pins
`timescale 1ns/1ps
`default_nettype none
`include "stw_map.svh"

module stw_ctrl
  import stw_pkg::*;
#(
  parameter int TW = 4
) (
  // clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        wait_n,
  input  wire logic        manual_reset_n,
  input  wire logic        standby_req,
  // access request port
  input  wire logic        acc_req,
  input  wire logic [1:0]  acc_area,
  input  wire logic        acc_write,
  input  wire logic [3:0]  acc_beats,
  input  wire logic        refresh_req,
  // access progress
  output logic             acc_busy,
  output logic             beat_done,
  output logic             acc_done,
  // sdram commands
  output logic             sd_activate,
  output logic             sd_read,
  output logic             sd_write,
  output logic             sd_precharge,
  output logic             sd_auto_refresh,
  output logic             sd_self_refresh,
  output logic [1:0]       cas_latency,
  output logic [3:0]       row_start_bit
);

  stw_ctrl_t s;
  stw_ctrl_t n;

  logic          sq_load;
  logic [TW-1:0] sq_val;
  logic          sq_zero;
  logic          lk_load;
  logic [TW-1:0] lk_val;
  logic          lk_zero;

  logic          hit;
  logic          wr_en;
  logic [31:0]   rdata;
  logic [1:0]    sel_area;
  logic          sel_sd;
  logic [3:0]    first_waits;
  logic [3:0]    pitch;
  logic [1:0]    sel_code2;
  logic [1:0]    cl_val;
  logic          wait_act;
  logic          mrst;
  logic          stby;
  logic [3:0]    tpc;
  logic [3:0]    rcd;
  logic [3:0]    trwl;
  logic [3:0]    tras;
  logic          rf_en;
  logic          rf_self;

  // literals cannot be part-selected, so the tables live in constants
  localparam logic [31:0] A0_FIRST_TBL = `STW_A0_FIRST;
  localparam logic [31:0] A0_PITCH_TBL = `STW_A0_PITCH;
  localparam logic [7:0]  CL_TBL       = `STW_CL_TBL;

  // sequencing counter: first-cycle waits, pitch, rcd and cas latency
  stw_timer #(.W(TW)) u_seq (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (sq_load),
    .load_val (sq_val),
    .zero     (sq_zero)
  );

  // activate lockout after precharge, write or refresh
  stw_timer #(.W(TW)) u_lock (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (lk_load),
    .load_val (lk_val),
    .zero     (lk_zero)
  );

  assign hit      = (paddr == `STW_OFF_WCR) || (paddr == `STW_OFF_MTC) ||
                    (paddr == `STW_OFF_ATY) || (paddr == `STW_OFF_STAT);
  assign wr_en    = psel && penable && s.pready && pwrite;
  // only the second sync stage is read
  assign wait_act = !s.ws_sync[1];
  assign mrst     = !s.mr_sync[1];
  assign stby     = s.sb_sync[1];
  assign sel_area = (s.st == ph_idle) ? acc_area : s.area;
  assign sel_sd   = ((sel_area == `STW_AREA2) && s.aty[`STW_ATY_A2SD]) ||
                    ((sel_area == `STW_AREA3) && s.aty[`STW_ATY_A3SD]);
  assign sel_code2 = (sel_area == `STW_AREA3) ? s.wcr[`STW_WCR_A3] : s.wcr[`STW_WCR_A2];
  assign first_waits = (sel_area == `STW_AREA2 || sel_area == `STW_AREA3) ?
                       {2'h0, sel_code2} :
                       A0_FIRST_TBL[{s.wcr[`STW_WCR_A0], 2'h0} +: 4];
  assign pitch    = A0_PITCH_TBL[{s.wcr[`STW_WCR_A0], 2'h0} +: 4];
  assign cl_val   = CL_TBL[{sel_code2, 1'b0} +: 2];
  assign tpc      = {2'h0, s.mtc[`STW_MTC_TPC]} + `STW_TPC_BASE;
  assign rcd      = {2'h0, s.mtc[`STW_MTC_RCD]} + `STW_RCD_BASE;
  assign trwl     = {2'h0, s.mtc[`STW_MTC_TRWL]} + `STW_TRWL_BASE;
  assign tras     = {2'h0, s.mtc[`STW_MTC_TRAS]} + `STW_TRAS_BASE;
  assign rf_en    = s.mtc[`STW_MTC_RFEN];
  assign rf_self  = s.mtc[`STW_MTC_RFKIND];

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      `STW_OFF_WCR:  rdata = {16'h0000, s.wcr};
      `STW_OFF_MTC:  rdata = {16'h0000, s.mtc & `STW_MTC_WMASK};
      `STW_OFF_ATY:  rdata = {30'h0, s.aty};
      `STW_OFF_STAT: rdata = {24'h0, s.st, s.busy, s.selfr, s.row_open, lk_zero, s.pend};
      default:       rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    n = s;
    sq_load = 1'b0;
    sq_val = '0;
    lk_load = 1'b0;
    lk_val = '0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.beat_done = 1'b0;
    n.acc_done = 1'b0;
    n.act = 1'b0;
    n.rd = 1'b0;
    n.wr = 1'b0;
    n.pre = 1'b0;
    n.aref = 1'b0;
    n.ws_sync = {s.ws_sync[0], wait_n};
    n.mr_sync = {s.mr_sync[0], manual_reset_n};
    n.sb_sync = {s.sb_sync[0], standby_req};
    n.cl = cl_val;
    case (s.mtc[`STW_MTC_AMX])
      `STW_AMX_A9_16, `STW_AMX_A9_32:   n.rowbit = `STW_ROW_A9;
      `STW_AMX_A10_8, `STW_AMX_A10_16:  n.rowbit = `STW_ROW_A10;
      `STW_AMX_A11_16:                  n.rowbit = `STW_ROW_A11;
      default:                          n.rowbit = `STW_ROW_NONE;
    endcase
    // one wait state, then answer
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = rdata;
    end
    if (wr_en) begin
      case (paddr)
        `STW_OFF_WCR: n.wcr = pwdata[15:0];
        `STW_OFF_MTC: n.mtc = pwdata[15:0] & `STW_MTC_WMASK;
        `STW_OFF_ATY: n.aty = pwdata[1:0];
        default:      n.aty = s.aty;
      endcase
    end
    case (s.st)
      ph_idle: begin
        if (mrst || stby) begin
          n.st = ph_idle;
        end else if (rf_en && rf_self) begin
          n.st = ph_self;
          n.selfr = 1'b1;
          n.pend = 1'b0;
        end else if (rf_en && s.pend) begin
          if (s.row_open) begin
            n.pre = 1'b1;
            n.row_open = 1'b0;
            lk_load = 1'b1;
            lk_val = TW'(tpc + (s.last_wr ? trwl : 4'h0));
          end else if (lk_zero) begin
            n.aref = 1'b1;
            n.pend = 1'b0;
            lk_load = 1'b1;
            lk_val = TW'(tpc + tras);
          end
        end else if (acc_req) begin
          n.busy = 1'b1;
          n.area = acc_area;
          n.write = acc_write;
          n.beats = acc_beats;
          if (sel_sd) begin
            n.st = ph_actw;
          end else begin
            n.st = ph_first;
            sq_load = 1'b1;
            sq_val = TW'(first_waits);
          end
        end
      end
      ph_first, ph_burst: begin
        // zero first-cycle waits ignore the pin; burst beats always honour it
        if (sq_zero && !(wait_act && (s.st == ph_burst || first_waits != 4'h0))) begin
          n.beat_done = 1'b1;
          if (s.beats == 4'h0) begin
            n.acc_done = 1'b1;
            n.busy = 1'b0;
            n.st = ph_idle;
          end else begin
            n.beats = s.beats - `STW_ONE;
            n.st = ph_burst;
            sq_load = 1'b1;
            sq_val = (s.area == `STW_AREA0) ? TW'(pitch - `STW_ONE) : TW'(first_waits);
          end
        end
      end
      ph_actw: begin
        if (s.row_open) begin
          n.pre = 1'b1;
          n.row_open = 1'b0;
          lk_load = 1'b1;
          lk_val = TW'(tpc + (s.last_wr ? trwl : 4'h0));
        end else if (lk_zero) begin
          n.act = 1'b1;
          n.st = ph_rcd;
          sq_load = 1'b1;
          sq_val = TW'(rcd - `STW_ONE);
        end
      end
      ph_rcd: begin
        if (sq_zero) begin
          n.st = ph_data;
          n.rd = !s.write;
          n.wr = s.write;
          n.last_wr = s.write;
          sq_load = 1'b1;
          sq_val = s.write ? TW'(0) : TW'({2'h0, cl_val} - `STW_ONE);
        end
      end
      ph_data: begin
        if (sq_zero) begin
          n.beat_done = 1'b1;
          if (s.beats == 4'h0) begin
            n.acc_done = 1'b1;
            n.busy = 1'b0;
            n.st = ph_idle;
            if (s.mtc[`STW_MTC_BANK]) begin
              n.row_open = 1'b1;
            end else begin
              lk_load = 1'b1;
              lk_val = TW'(tpc + (s.last_wr ? trwl : 4'h0));
            end
          end else begin
            n.beats = s.beats - `STW_ONE;
          end
        end
      end
      ph_self: begin
        // refresh requests are dropped while the memory refreshes itself
        n.pend = 1'b0;
        if (!rf_en || !rf_self) begin
          n.selfr = 1'b0;
          n.st = ph_idle;
        end
      end
      default: n.st = ph_idle;
    endcase
    // set wins over the clear made above
    if (refresh_req && rf_en && !rf_self && s.st != ph_self) begin
      n.pend = 1'b1;
    end
    // manual reset aborts the access but keeps every register
    if (mrst) begin
      n.st = ph_idle;
      n.busy = 1'b0;
      n.selfr = 1'b0;
      n.pend = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.wcr <= `STW_WCR_RST;
      s.mtc <= `STW_MTC_RST;
      s.aty <= `STW_ATY_RST;
      s.ws_sync <= 2'h3;
      s.mr_sync <= 2'h3;
      s.cl <= 2'h3;
    end else begin
      s <= n;
    end
  end

  assign prdata          = s.prdata;
  assign pready          = s.pready;
  assign pslverr         = s.pslverr;
  assign acc_busy        = s.busy;
  assign beat_done       = s.beat_done;
  assign acc_done        = s.acc_done;
  assign sd_activate     = s.act;
  assign sd_read         = s.rd;
  assign sd_write        = s.wr;
  assign sd_precharge    = s.pre;
  assign sd_auto_refresh = s.aref;
  assign sd_self_refresh = s.selfr;
  assign cas_latency     = s.cl;
  assign row_start_bit   = s.rowbit;

  mtc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `STW_OFF_MTC |=> s.mtc[15:1] == $past(pwdata[15:1]))
    else $error("control register write lost");
  mtc_bit0_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.pready && paddr == `STW_OFF_MTC && !pwrite |-> !prdata[0] && !s.mtc[0])
    else $error("control bit 0 not zero");
  a2_waits_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == ph_idle && n.st == ph_first && acc_area == `STW_AREA2 &&
    s.wcr[`STW_WCR_A2] == 2'h3 |=> !s.beat_done [*4])
    else $error("area 2 beat before three waits");
  a0_waits_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == ph_idle && n.st == ph_first && acc_area == `STW_AREA0 &&
    s.wcr[`STW_WCR_A0] == 3'h7 |=> !s.beat_done [*8] ##1 !s.beat_done ##1 !s.beat_done)
    else $error("area 0 beat before ten waits");
  wait_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.st == ph_burst && sq_zero && wait_act |=> !s.beat_done)
    else $error("burst beat taken during wait");
  cas_lat_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.rd && s.cl == 2'h3 |-> ##1 !s.beat_done [*2] ##1 s.beat_done)
    else $error("read data not at latency three");
  rcd_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.act && s.mtc[`STW_MTC_RCD] == 2'h3 |-> ##1 !(s.rd || s.wr) [*3] ##1 (s.rd || s.wr))
    else $error("row to column delay not four");
  pre_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.pre && s.mtc[`STW_MTC_TPC] == 2'h3 |-> !s.act [*5])
    else $error("activate too soon after precharge");
  ref_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.aref && s.mtc[`STW_MTC_TPC] == 2'h0 && s.mtc[`STW_MTC_TRAS] == 2'h3 |-> !s.act [*7])
    else $error("activate too soon after refresh");
  self_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.selfr |-> !s.aref && !s.act)
    else $error("command during self refresh");

endmodule : stw_ctrl

`default_nettype wire

// [src/stw_map.svh]
// register offsets, field positions, reset values and timing tables
// assumes 32-bit apb data and a 12-bit byte address
`ifndef STW_MAP_SVH
`define STW_MAP_SVH

`define STW_AW           12
`define STW_OFF_WCR      12'h000
`define STW_OFF_MTC      12'h004
`define STW_OFF_ATY      12'h008
`define STW_OFF_STAT     12'h00c

`define STW_WCR_RST      16'hffff
`define STW_MTC_RST      16'h0000
`define STW_MTC_WMASK    16'hfffe
`define STW_ATY_RST      2'h0

`define STW_WCR_A3       6:5
`define STW_WCR_A2       4:3
`define STW_WCR_A0       2:0
`define STW_MTC_TPC      15:14
`define STW_MTC_RCD      13:12
`define STW_MTC_TRWL     11:10
`define STW_MTC_TRAS     9:8
`define STW_MTC_BANK     7
`define STW_MTC_AMX      6:3
`define STW_MTC_RFEN     2
`define STW_MTC_RFKIND   1
`define STW_ATY_A2SD     0
`define STW_ATY_A3SD     1

`define STW_AREA0        2'h0
`define STW_AREA2        2'h2
`define STW_AREA3        2'h3

// four-bit entries (two-bit in the cas latency table), code 0 in the lowest bits
`define STW_A0_FIRST     32'ha864_3210
`define STW_A0_PITCH     32'ha864_4322
`define STW_CL_TBL       8'he5
`define STW_TPC_BASE     4'h1
`define STW_RCD_BASE     4'h1
`define STW_TRWL_BASE    4'h1
`define STW_TRAS_BASE    4'h2
`define STW_ONE          4'h1

`define STW_AMX_A9_16    4'h4
`define STW_AMX_A10_8    4'h5
`define STW_AMX_A9_32    4'h7
`define STW_AMX_A10_16   4'hd
`define STW_AMX_A11_16   4'he
`define STW_ROW_A9       4'h9
`define STW_ROW_A10      4'ha
`define STW_ROW_A11      4'hb
`define STW_ROW_NONE     4'h0

`endif

// [src/stw_pkg.sv]
// types shared by the wait and sdram timing controller
// assumes stw_map.svh supplies the numeric constants other than the phase codes, which are set here
package stw_pkg;

  typedef enum logic [2:0] {
    ph_idle  = 3'b000,
    ph_first = 3'b001,
    ph_burst = 3'b010,
    ph_actw  = 3'b011,
    ph_rcd   = 3'b100,
    ph_data  = 3'b101,
    ph_self  = 3'b110
  } stw_phase_t;

  typedef struct packed {
    stw_phase_t  st;
    logic [15:0] wcr;
    logic [15:0] mtc;
    logic [1:0]  aty;
    logic [1:0]  ws_sync;
    logic [1:0]  mr_sync;
    logic [1:0]  sb_sync;
    logic [1:0]  area;
    logic        write;
    logic        last_wr;
    logic [3:0]  beats;
    logic        row_open;
    logic        pend;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        busy;
    logic        beat_done;
    logic        acc_done;
    logic        act;
    logic        rd;
    logic        wr;
    logic        pre;
    logic        aref;
    logic        selfr;
    logic [1:0]  cl;
    logic [3:0]  rowbit;
  } stw_ctrl_t;

endpackage : stw_pkg

// [src/stw_timer.sv]
// loadable down counter that stops at zero
// assumes load comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module stw_timer #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // state
  output logic              zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } stw_tmr_t;

  stw_tmr_t s;
  stw_tmr_t n;

  always_comb begin
    n = s;
    if (load) begin
      n.cnt = load_val;
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign zero = (s.cnt == '0);

endmodule : stw_timer

`default_nettype wire
